// ==== shared/atsp_pkg.sv ====
// acquisition trigger and strobe sequencer: shared constants and types
`default_nettype none
package atsp_pkg;
    // clock and tick
    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned TICK_PS = 1000000;
    localparam int unsigned TICK_CYCLES = TICK_PS / CLK_PERIOD_PS;
    // widths
    localparam int unsigned US_W = 23;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned SCAN_W = 16;
    // register offsets
    localparam logic [ADDR_W-1:0] OFF_CFG = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CMD = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_ACQ_DELAY = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_WINDOW = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_SCANS = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_SS_DELAY = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_SS_WIDTH = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_CS_PERIOD = 8'h1C;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h20;
    // field positions
    localparam int unsigned CFG_MODE_LSB = 0;
    localparam int unsigned CFG_AVG_BIT = 2;
    localparam int unsigned CMD_TRIG_BIT = 0;
    localparam int unsigned CMD_ACK_BIT = 1;
    localparam int unsigned ST_BUSY_BIT = 0;
    localparam int unsigned ST_WINDOW_BIT = 1;
    localparam int unsigned ST_READY_BIT = 2;
    // times in microseconds (one tick each)
    localparam logic [US_W-1:0] ACQ_DELAY_MAX_US = 23'd335500;
    localparam logic [US_W-1:0] WINDOW_MIN_US = 23'd1;
    localparam logic [US_W-1:0] WINDOW_MAX_US = 23'd6000000;
    localparam logic [US_W-1:0] INIT_BUSY_SPLIT_US = 23'd218;
    localparam logic [US_W-1:0] INIT_BUSY_BASE_US = 23'd219;
    localparam logic [US_W-1:0] INIT_BUSY_MIN_US = 23'd1;
    localparam logic [US_W-1:0] FINAL_BUSY_US = 23'd218;
    // reset values
    localparam logic [US_W-1:0] WINDOW_RST = 23'h0064;
    localparam logic [SCAN_W-1:0] SCANS_RST = 16'h0001;
    // trigger modes
    typedef enum logic [1:0] {
        TRIG_HOST = 2'h0,
        TRIG_EDGE = 2'h1,
        TRIG_LEVEL = 2'h2
    } atsp_trig_mode_e;
endpackage
`default_nettype wire

// ==== rtl/atsp_tick.sv ====
// one microsecond tick divider, restartable
`timescale 1ns/1ps
`default_nettype none
module atsp_tick
    import atsp_pkg::*;
#(
    parameter int unsigned CYCLES = TICK_CYCLES
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control and tick
    input wire logic clr_i,
    output logic tick_o
);
    localparam int unsigned W = $clog2(CYCLES);
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);
    logic [W-1:0] cnt;

    // count clock cycles, pulse once per period
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cnt <= '0;
            tick_o <= 1'b0;
        end
        else if (clr_i)
        begin
            cnt <= '0;
            tick_o <= 1'b0;
        end
        else
        begin
            cnt <= (cnt == LAST) ? '0 : cnt + 1'b1;
            tick_o <= (cnt == LAST);
        end
    end
endmodule
`default_nettype wire

// ==== rtl/atsp_strobe.sv ====
// single and periodic strobe generator
`timescale 1ns/1ps
`default_nettype none
module atsp_strobe
    import atsp_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // timing from the sequencer
    input wire logic tick_i,
    input wire logic event_i,
    input wire logic win_start_i,
    input wire logic win_active_i,
    input wire logic level_mode_i,
    input wire logic [US_W-1:0] remain_i,
    input wire logic [US_W-1:0] win_len_i,
    // settings
    input wire logic [US_W-1:0] ss_delay_i,
    input wire logic [US_W-1:0] ss_width_i,
    input wire logic [US_W-1:0] cs_period_i,
    // strobes
    output logic ss_o,
    output logic cs_o
);
    logic ss_armed;
    logic [US_W:0] ss_el;
    logic act_q;
    logic cs_run;
    logic [US_W-1:0] cs_ph;

    // derived terms
    wire win_end = act_q & ~win_active_i;
    // a restart while open ends the first window of an averaged cycle
    wire ss_cut = win_end | (win_start_i & act_q);
    wire [US_W:0] ss_rel = ss_el - {1'b0, ss_delay_i};
    wire ss_on = (ss_el >= {1'b0, ss_delay_i})
        & (ss_rel < {1'b0, ss_width_i});
    wire cs_en = (cs_period_i != '0)
        & (level_mode_i | (cs_period_i < win_len_i));
    wire [US_W-1:0] cs_last = cs_period_i - 1'b1;
    wire [US_W-1:0] cs_hi = US_W'(({1'b0, cs_period_i} + 1'b1) >> 1);
    wire cs_wrap = tick_i & (cs_ph == cs_last);
    wire cs_fits = level_mode_i | (remain_i > cs_period_i);

    // single strobe: count from trigger event, disarm at end of integration
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ss_armed <= 1'b0;
            ss_el <= '0;
            act_q <= 1'b0;
            ss_o <= 1'b0;
        end
        else
        begin
            act_q <= win_active_i;
            if (event_i)
            begin
                ss_armed <= 1'b1;
                ss_el <= '0;
            end
            else if (ss_cut)
                ss_armed <= 1'b0;
            else if (tick_i && ss_el != '1)
                ss_el <= ss_el + 1'b1;
            ss_o <= ss_armed & ~event_i & ~ss_cut & ss_on;
        end
    end

    // periodic strobe: inside integration only, whole periods except in level mode
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cs_run <= 1'b0;
            cs_ph <= '0;
            cs_o <= 1'b0;
        end
        else
        begin
            if (win_start_i)
            begin
                cs_run <= cs_en;
                cs_ph <= '0;
            end
            else if (!win_active_i)
                cs_run <= 1'b0;
            else if (cs_run && cs_wrap)
            begin
                cs_run <= cs_fits;
                cs_ph <= '0;
            end
            else if (cs_run && tick_i)
                cs_ph <= cs_ph + 1'b1;
            cs_o <= (win_start_i ? cs_en : cs_run & ~(cs_wrap & ~cs_fits))
                & win_active_i
                & ((win_start_i | cs_wrap) ? 1'b1 : (cs_ph < cs_hi));
        end
    end
endmodule
`default_nettype wire

// ==== rtl/atsp_top.sv ====
// acquisition sequencer with apb registers, trigger input and strobes
`timescale 1ns/1ps
`default_nettype none
module atsp_top
    import atsp_pkg::*;
#(
    parameter int unsigned TICK_CYC = TICK_CYCLES
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // external trigger pin
    input wire logic ext_trig_i,
    // acquisition status
    output logic busy_o,
    output logic integrating_o,
    output logic data_ready_o,
    // strobes
    output logic single_strobe_o,
    output logic periodic_strobe_o
);
    typedef enum {
        ST_IDLE,
        ST_DELAY,
        ST_WINDOW,
        ST_FINAL,
        ST_READOUT
    } atsp_state_e;

    // configuration registers
    logic [1:0] trigger_mode;
    logic averaging_acquisition_mode;
    logic [US_W-1:0] acquisition_delay;
    logic [US_W-1:0] integration_length;
    logic [SCAN_W-1:0] scans_to_average;
    logic [US_W-1:0] ss_delay;
    logic [US_W-1:0] ss_width;
    logic [US_W-1:0] periodic_strobe_period;

    // sequencer state
    atsp_state_e state;
    atsp_state_e next_state;
    logic [US_W-1:0] cnt;
    logic [US_W-1:0] next_cnt;
    logic [SCAN_W-1:0] scans_left;
    logic [SCAN_W-1:0] next_scans_left;
    logic win_start;
    logic next_win_start;
    logic trig_event;

    // trigger synchroniser and edge history
    logic trig_m;
    logic trig_s;
    logic trig_d;

    // microsecond tick
    logic tick;

    // apb access decode
    wire apb_first = psel_i & penable_i & ~pready_o;
    wire apb_wr = psel_i & penable_i & pready_o & pwrite_i;
    wire hit_cfg = (paddr_i == OFF_CFG);
    wire hit_cmd = (paddr_i == OFF_CMD);
    wire hit_acq = (paddr_i == OFF_ACQ_DELAY);
    wire hit_win = (paddr_i == OFF_WINDOW);
    wire hit_scans = (paddr_i == OFF_SCANS);
    wire hit_ssd = (paddr_i == OFF_SS_DELAY);
    wire hit_ssw = (paddr_i == OFF_SS_WIDTH);
    wire hit_csp = (paddr_i == OFF_CS_PERIOD);
    wire hit_stat = (paddr_i == OFF_STATUS);
    wire mapped = hit_cfg | hit_cmd | hit_acq | hit_win | hit_scans
        | hit_ssd | hit_ssw | hit_csp | hit_stat;

    // command strobes from a completed write
    wire host_trig = apb_wr & hit_cmd & pwdata_i[CMD_TRIG_BIT];
    wire host_ack = apb_wr & hit_cmd & pwdata_i[CMD_ACK_BIT];

    // write data limited to the legal ranges
    wire [US_W-1:0] wr_us = pwdata_i[US_W-1:0];
    wire wr_us_big = (pwdata_i[31:US_W] != '0);
    wire [US_W-1:0] wr_acq = (wr_us_big || wr_us > ACQ_DELAY_MAX_US)
        ? ACQ_DELAY_MAX_US : wr_us;
    wire [US_W-1:0] wr_win = (wr_us_big || wr_us > WINDOW_MAX_US)
        ? WINDOW_MAX_US
        : ((wr_us < WINDOW_MIN_US) ? WINDOW_MIN_US : wr_us);
    wire [SCAN_W-1:0] wr_scans = (pwdata_i[SCAN_W-1:0] == '0)
        ? SCANS_RST : pwdata_i[SCAN_W-1:0];

    // config and status words, fields at their package positions
    logic [31:0] rd_cfg;
    logic [31:0] rd_stat;
    always_comb
    begin
        rd_cfg = 32'h0000_0000;
        rd_cfg[CFG_MODE_LSB +: 2] = trigger_mode;
        rd_cfg[CFG_AVG_BIT] = averaging_acquisition_mode;
        rd_stat = 32'h0000_0000;
        rd_stat[ST_BUSY_BIT] = busy_o;
        rd_stat[ST_WINDOW_BIT] = integrating_o;
        rd_stat[ST_READY_BIT] = data_ready_o;
    end

    // read word selection, unmapped reads as zero
    wire [31:0] rd_word =
        hit_cfg ? rd_cfg :
        hit_acq ? {9'h000, acquisition_delay} :
        hit_win ? {9'h000, integration_length} :
        hit_scans ? {16'h0000, scans_to_average} :
        hit_ssd ? {9'h000, ss_delay} :
        hit_ssw ? {9'h000, ss_width} :
        hit_csp ? {9'h000, periodic_strobe_period} :
        hit_stat ? rd_stat : 32'h0000_0000;

    // mode decode
    wire mode_host = (trigger_mode == TRIG_HOST);
    wire mode_edge = (trigger_mode == TRIG_EDGE);
    wire mode_level = (trigger_mode == TRIG_LEVEL);
    wire trig_rise = trig_s & ~trig_d;
    // averaging never combines with level triggering
    wire avg_on = averaging_acquisition_mode & ~mode_level;

    // initial busy depends on integration length
    wire [US_W-1:0] init_busy = (integration_length >= INIT_BUSY_SPLIT_US)
        ? INIT_BUSY_MIN_US
        : INIT_BUSY_BASE_US - integration_length;
    wire [US_W-1:0] first_wait = acquisition_delay + init_busy;

    // trigger source selection, only while idle
    wire want_trig = (mode_host & host_trig)
        | ((mode_edge | mode_level) & trig_rise);
    wire take_trig = (state == ST_IDLE) & want_trig;

    // end of one integration window
    wire win_done = mode_level
        ? ~trig_s
        : (tick & (cnt == 23'd1));
    wire more_scans = avg_on & (scans_left > 16'h0001);

    // apb answer: one wait cycle, error on unmapped address
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= '0;
        end
        else
        begin
            pready_o <= apb_first;
            pslverr_o <= apb_first & ~mapped;
            prdata_o <= apb_first ? rd_word : '0;
        end
    end

    // configuration registers
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            trigger_mode <= TRIG_HOST;
            averaging_acquisition_mode <= 1'b0;
            acquisition_delay <= '0;
            integration_length <= WINDOW_RST;
            scans_to_average <= SCANS_RST;
            ss_delay <= '0;
            ss_width <= '0;
            periodic_strobe_period <= '0;
        end
        else if (apb_wr)
        begin
            if (hit_cfg)
            begin
                trigger_mode <= pwdata_i[CFG_MODE_LSB +: 2];
                averaging_acquisition_mode <= pwdata_i[CFG_AVG_BIT];
            end
            if (hit_acq)
                acquisition_delay <= wr_acq;
            if (hit_win)
                integration_length <= wr_win;
            if (hit_scans)
                scans_to_average <= wr_scans;
            if (hit_ssd)
                ss_delay <= wr_us;
            if (hit_ssw)
                ss_width <= wr_us;
            if (hit_csp)
                periodic_strobe_period <= wr_us;
        end
    end

    // external trigger synchroniser and edge history
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            trig_m <= 1'b0;
            trig_s <= 1'b0;
            trig_d <= 1'b0;
        end
        else
        begin
            trig_m <= ext_trig_i;
            trig_s <= trig_m;
            trig_d <= trig_s;
        end
    end

    // sequencer next state
    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_scans_left = scans_left;
        next_win_start = 1'b0;
        case (state)
            ST_IDLE:
            begin
                if (take_trig)
                begin
                    next_state = ST_DELAY;
                    next_cnt = first_wait;
                    next_scans_left = avg_on ? scans_to_average : 16'h0001;
                end
            end
            ST_DELAY:
            begin
                if (tick)
                begin
                    if (cnt == 23'd1)
                    begin
                        next_state = ST_WINDOW;
                        next_cnt = integration_length;
                        next_win_start = 1'b1;
                    end
                    else
                        next_cnt = cnt - 1'b1;
                end
            end
            ST_WINDOW:
            begin
                if (win_done)
                begin
                    if (more_scans)
                    begin
                        next_cnt = integration_length;
                        next_scans_left = scans_left - 1'b1;
                        next_win_start = 1'b1;
                    end
                    else
                    begin
                        next_state = ST_FINAL;
                        next_cnt = FINAL_BUSY_US;
                    end
                end
                else if (tick && cnt != '0)
                    next_cnt = cnt - 1'b1;
            end
            ST_FINAL:
            begin
                if (tick)
                begin
                    if (cnt == 23'd1)
                        next_state = ST_READOUT;
                    else
                        next_cnt = cnt - 1'b1;
                end
            end
            ST_READOUT:
            begin
                if (host_ack)
                    next_state = ST_IDLE;
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // sequencer registers and status outputs
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state <= ST_IDLE;
            cnt <= '0;
            scans_left <= '0;
            win_start <= 1'b0;
            trig_event <= 1'b0;
            busy_o <= 1'b0;
            integrating_o <= 1'b0;
            data_ready_o <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            scans_left <= next_scans_left;
            win_start <= next_win_start;
            trig_event <= take_trig;
            busy_o <= (next_state != ST_IDLE);
            integrating_o <= (next_state == ST_WINDOW);
            data_ready_o <= (next_state == ST_READOUT);
        end
    end

    // microsecond tick, realigned to each trigger event
    atsp_tick #(
        .CYCLES(TICK_CYC)
    ) u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clr_i(take_trig),
        .tick_o(tick)
    );

    // strobe outputs
    atsp_strobe u_strobe (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tick),
        .event_i(trig_event),
        .win_start_i(win_start),
        .win_active_i(integrating_o),
        .level_mode_i(mode_level),
        .remain_i(cnt),
        .win_len_i(integration_length),
        .ss_delay_i(ss_delay),
        .ss_width_i(ss_width),
        .cs_period_i(periodic_strobe_period),
        .ss_o(single_strobe_o),
        .cs_o(periodic_strobe_o)
    );
endmodule
`default_nettype wire

// ==== verification/atsp_top_asserts.sv ====
// port-level timing checks for the acquisition sequencer
`timescale 1ns/1ps
`default_nettype none
module atsp_top_asserts
    import atsp_pkg::*;
#(
    parameter int unsigned TICK_CYC = TICK_CYCLES
)
(
    // clock, reset and apb answer
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // status and strobes
    input wire logic busy_o,
    input wire logic integrating_o,
    input wire logic data_ready_o,
    input wire logic single_strobe_o,
    input wire logic periodic_strobe_o
);
    localparam int FB = 218 * TICK_CYC;
    logic [19:0] since_int;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // cycles since the integration window closed
    always_ff @(posedge clk_i or posedge rst_i)
        if (rst_i)
            since_int <= 20'h0_0000;
        else if (integrating_o)
            since_int <= 20'h0_0000;
        else if (!since_int[19])
            since_int <= since_int + 20'h0_0001;
    // apb setup then access steps
    sequence s_setup;
        psel_i && !penable_i;
    endsequence
    sequence s_access;
        psel_i && penable_i;
    endsequence
    AST_APB_ANSWER: assert property (s_setup ##1 s_access |=> pready_o)
        else $error("pready late");
    AST_READY_PULSE: assert property (pready_o |=> !pready_o)
        else $error("pready held");
    AST_ERR_QUAL: assert property (pslverr_o |-> pready_o)
        else $error("pslverr alone");
    AST_WINDOW_IN_CYCLE: assert property (integrating_o |-> busy_o)
        else $error("window outside cycle");
    AST_INIT_BUSY: assert property ($rose(busy_o) |-> !integrating_o [*3])
        else $error("window opened too soon");
    AST_FINAL_BUSY: assert property ($rose(data_ready_o) |->
        since_int inside {[FB - 3:FB + 3]})
        else $error("final busy length wrong");
    AST_READY_AFTER: assert property (data_ready_o |-> busy_o && !integrating_o)
        else $error("data ready out of place");
    AST_DELIVERED: assert property ($fell(data_ready_o) |-> !busy_o)
        else $error("busy after delivery");
    AST_SS_CUT: assert property ($fell(integrating_o) |=> !single_strobe_o)
        else $error("single strobe past window");
    AST_SS_IN_CYCLE: assert property (single_strobe_o |-> busy_o)
        else $error("single strobe while idle");
    AST_CS_IN_WINDOW: assert property (periodic_strobe_o |->
        integrating_o || $past(integrating_o))
        else $error("periodic strobe outside window");
endmodule
bind atsp_top atsp_top_asserts #(.TICK_CYC(TICK_CYC)) u_asserts (
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .busy_o(busy_o),
    .integrating_o(integrating_o), .data_ready_o(data_ready_o),
    .single_strobe_o(single_strobe_o),
    .periodic_strobe_o(periodic_strobe_o));
`default_nettype wire

// ==== verification/atsp_trig_src.sv ====
// external trigger source: one high pulse per request
`timescale 1ns/1ps
`default_nettype none
module atsp_trig_src (
    // clock and request
    input wire logic clk_i,
    input wire logic fire_i,
    input wire logic [15:0] len_i,
    // trigger pin
    output logic trig_o
);
    logic [15:0] left = 16'h0000;
    // pulse of len_i cycles, never shorter than 10 ns
    always @(posedge clk_i)
    begin
        if (fire_i && left == 16'h0000)
            left <= (len_i < 16'h0002) ? 16'h0002 : len_i;
        else if (left != 16'h0000)
            left <= left - 16'h0001;
    end
    assign trig_o = left != 16'h0000; // low between pulses
endmodule
`default_nettype wire

// ==== verification/test_atsp_top.sv ====
// self-checking bench for the acquisition sequencer
`timescale 1ns/1ps
`default_nettype none
module test_atsp_top
    import atsp_pkg::*;
;
    localparam int T = 4;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic fire = 1'b0;
    logic [ADDR_W-1:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0000_0000;
    logic [15:0] plen = 16'h0002;
    logic [31:0] prdata_o, rv;
    logic pready_o, pslverr_o, ext_trig_i, busy_o, integrating_o, re, pc;
    logic data_ready_o, single_strobe_o, periodic_strobe_o;
    int err_total = 0;
    int compares = 0;
    int cyc = 0;
    int ti, ni, ncs, ts, nss;
    // design and trigger source
    atsp_top #(.TICK_CYC(T)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .ext_trig_i(ext_trig_i),
        .busy_o(busy_o), .integrating_o(integrating_o),
        .data_ready_o(data_ready_o), .single_strobe_o(single_strobe_o),
        .periodic_strobe_o(periodic_strobe_o));
    atsp_trig_src src_u (.clk_i(clk_i), .fire_i(fire), .len_i(plen),
        .trig_o(ext_trig_i));
    // clock
    initial forever #2.5 clk_i = ~clk_i;
    // run ceiling
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            err_total++;
            end_of_test();
        end
    end
    task automatic chk(input string nm, input logic [31:0] s,
        input logic [31:0] x);
        compares++;
        if (s !== x)
        begin
            err_total++;
            $display("ERROR %s expected %0h seen %0h", nm, x, s);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do
            @(posedge clk_i);
        while (pready_o !== 1'b1);
        rv = prdata_o;
        re = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x,
        input logic xe);
        apb(1'b0, a, 32'h0000_0000);
        chk("rdata", rv, x);
        chk("pslverr", re, xe);
    endtask
    function automatic logic near(input int s, input int x);
        return s >= x - 3 && s <= x + 3;
    endfunction
    function automatic int b1(input int i);
        return (i >= 218) ? 1 : 219 - i;
    endfunction
    task automatic pulse;
        fire <= 1'b1;
        @(posedge clk_i);
        fire <= 1'b0;
        @(posedge clk_i);
    endtask
    // follow one cycle until data ready, then acknowledge it
    task automatic watch(input int e, input int l);
        int n;
        n = 0;
        ti = -1;
        ni = 0;
        ncs = 0;
        ts = -1;
        nss = 0;
        pc = 1'b0;
        while (data_ready_o !== 1'b1)
        begin
            @(posedge clk_i);
            n++;
            if (integrating_o === 1'b1 && ti < 0)
                ti = n;
            ni += (integrating_o === 1'b1);
            ncs += (periodic_strobe_o === 1'b1 && pc !== 1'b1);
            pc = periodic_strobe_o;
            if (single_strobe_o === 1'b1 && ts < 0)
                ts = n;
            nss += (single_strobe_o === 1'b1);
        end
        chk("start", near(ti, e), 1'b1);
        chk("length", near(ni, l), 1'b1);
        rd(OFF_STATUS, 32'h0000_0005, 1'b0);
        wr(OFF_CMD, 32'h0000_0002);
        repeat (60) @(posedge clk_i);
        chk("busy", busy_o, 1'b0);
    endtask
    task automatic end_of_test;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // main sequence
    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("outs", busy_o | single_strobe_o | periodic_strobe_o, 1'b0);
        rd(OFF_CFG, 32'h0000_0000, 1'b0);
        rd(OFF_WINDOW, 32'h0000_0064, 1'b0);
        rd(8'h24, 32'h0000_0000, 1'b1);
        wr(OFF_ACQ_DELAY, 32'h007f_ffff);
        rd(OFF_ACQ_DELAY, 32'h0005_1e8c, 1'b0);
        wr(OFF_WINDOW, 32'h0000_0000);
        rd(OFF_WINDOW, 32'h0000_0001, 1'b0);
        wr(OFF_WINDOW, 32'h007f_ffff);
        rd(OFF_WINDOW, 32'h005b_8d80, 1'b0);
        // host trigger with both strobes, retrigger while busy
        wr(OFF_ACQ_DELAY, 32'h0000_0002);
        wr(OFF_WINDOW, 32'h0000_000a);
        wr(OFF_SS_DELAY, 32'h0000_0003);
        wr(OFF_SS_WIDTH, 32'h0000_0002);
        wr(OFF_CS_PERIOD, 32'h0000_0004);
        wr(OFF_CMD, 32'h0000_0001);
        fork
            watch((2 + b1(10)) * T, 10 * T);
            begin
                repeat (100) @(posedge clk_i);
                wr(OFF_CMD, 32'h0000_0001);
            end
        join
        chk("ss_at", near(ts, 3 * T), 1'b1);
        chk("ss_len", near(nss, 2 * T), 1'b1);
        chk("cs_n", ncs, 32'h0000_0002);
        // edge trigger, strobe cut at window end, period too long
        wr(OFF_CFG, 32'h0000_0001);
        wr(OFF_ACQ_DELAY, 32'h0000_0000);
        wr(OFF_WINDOW, 32'h0000_00fa);
        wr(OFF_SS_DELAY, 32'h0000_0000);
        wr(OFF_SS_WIDTH, 32'h0000_0190);
        wr(OFF_CS_PERIOD, 32'h0000_00fa);
        wr(OFF_CMD, 32'h0000_0001);
        repeat (2) @(posedge clk_i);
        chk("busy", busy_o, 1'b0);
        pulse();
        fork
            watch(b1(250) * T + 3, 250 * T);
            begin
                repeat (200) @(posedge clk_i);
                pulse();
            end
        join
        chk("ss_cut", near(nss, 251 * T), 1'b1);
        chk("cs_n", ncs, 32'h0000_0000);
        // level trigger: window follows the pin, averaging ignored
        wr(OFF_CFG, 32'h0000_0006);
        wr(OFF_SCANS, 32'h0000_0003);
        wr(OFF_WINDOW, 32'h0000_012c);
        plen <= 16'h00f0;
        pulse();
        watch(b1(300) * T + 3, 240 - T);
        // averaging three windows back to back
        wr(OFF_CFG, 32'h0000_0004);
        wr(OFF_WINDOW, 32'h0000_00dc);
        wr(OFF_CS_PERIOD, 32'h0000_0000);
        wr(OFF_CMD, 32'h0000_0001);
        watch(b1(220) * T, 3 * 220 * T);
        chk("cs_n", ncs, 32'h0000_0000);
        chk("ss_avg", near(nss, 221 * T), 1'b1);
        // no trigger source selected
        wr(OFF_CFG, 32'h0000_0003);
        wr(OFF_CMD, 32'h0000_0001);
        pulse();
        repeat (8) @(posedge clk_i);
        chk("busy", busy_o, 1'b0);
        end_of_test();
    end
endmodule
`default_nettype wire
